// ---- rtl/acs_corr.v ----
// Correction datapath: subtract offset, then multiply by the full-scale coefficient.
// Assumes gain is unsigned 1.23 fixed point, so 0x800000 means unity.
`timescale 1ns/100ps
module acs_corr (
   input wire clock_in,
   input wire rst_in,
   input wire [23:0] raw_in, // Raw filter word, offset binary
   input wire [23:0] offs_in,
   input wire [23:0] gain_in,
   input wire word24_in, // 1: 24-bit result, 0: 16-bit
   output reg [23:0] res_out
);
   // ==========================================
   // Arithmetic held at 33 bits internally
   wire signed [32:0] diff; // Raw minus offset, 33 bits
   wire signed [57:0] prod; // Full product before scaling
   wire signed [32:0] scaled; // Back to 33-bit precision
   wire [23:0] sat; // Clamped to 24-bit range
   assign diff = $signed({9'h000, raw_in}) - $signed({9'h000, offs_in});
   assign prod = diff * $signed({1'b0, gain_in});
   assign scaled = prod[55:23];
   // Clamp instead of wrap so an overrange input pins at a rail
   assign sat = scaled[32] ? 24'h00_0000 :
                (|scaled[31:24]) ? 24'hFF_FFFF : scaled[23:0];
   // Register result, truncating to 16 bits when asked
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in)
         res_out <= 24'h00_0000;
      else
         res_out <= word24_in ? sat : {sat[23:8], 8'h00};
   end
endmodule // acs_corr

// ---- rtl/acs_regs.vh ----
// Constants for the calibration sequencer: register offsets, fields, reset values, timing.
// Assumes a 32-bit AXI4-Lite slave with word-aligned byte addresses.
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
// ==========================================
// Register byte offsets
`define ACS_OFF_CTRL 12'h000
`define ACS_OFF_STAT 12'h004
`define ACS_OFF_OFFS 12'h008
`define ACS_OFF_GAIN 12'h00C
`define ACS_OFF_RES 12'h010
`define ACS_OFF_IRQS 12'h014
`define ACS_OFF_IRQC 12'h018
`define ACS_OFF_IRQE 12'h01C
// ==========================================
// Mode codes of cal_mode_bits
`define ACS_MD_NORMAL 3'h0
`define ACS_MD_SELF 3'h1
`define ACS_MD_SYS_ZERO 3'h2
`define ACS_MD_SYS_FULL 3'h3
`define ACS_MD_SYS_OFFS 3'h4
`define ACS_MD_BGND 3'h5
// ==========================================
// Control fields
`define ACS_CTRL_MODE_LSB 0
`define ACS_CTRL_BIPOLAR 3
`define ACS_CTRL_WORD24 4
// ==========================================
// Reset values
`define ACS_OFFS_RST 24'h00_0000
`define ACS_GAIN_RST 24'h80_0000
// ==========================================
// Timing: modulator cycle and output period in clocks
`define ACS_MOD_CYC 8'h10
`define ACS_OUT_PER 16'h0100
`define ACS_PER_SELF 4'h9
`define ACS_PER_SYS 4'h4
`define ACS_PER_BGND 4'h6
`define ACS_BGND_DIV 3'h6
`endif

// ---- rtl/acs_seq.v ----
// Calibration sequencer top: mode control, calibration ordering, coefficients,
// data-ready and an AXI4-Lite register slave.
// Assumes raw filter words arrive from same-clock logic, one per output period.
`timescale 1ns/100ps
`include "acs_regs.vh"
// Contract
// - Code 001 converts shorted then reference
// - Self-cal ready only after update, resettle
// - Bipolar uses midscale and positive full-scale
// - Code 010 calibrates system zero scale
// - Code 011 calibrates system full scale
// - Lone zero step keeps existing slope
// - Code 100 runs system offset calibration
// - Code 101 background cal, rate div six
// - Background stays until mode changes
// - First background result invalid, second settled
// - Ready goes high within one modulator cycle
// - Subtract offset, then multiply gain
// - Host may write coefficients directly
// - 33-bit arithmetic, 16 or 24 result
// - Any calibration command resets filter
// - Durations nine, four, six output periods
module acs_seq (
   input wire clock_in,
   input wire rst_in,
   // Converter side
   input wire [23:0] raw_data_in, // Filter word for the current node
   input wire data_read_in, // Host finished reading the result
   output reg [1:0] node_sel_out, // 0 input, 1 shorted, 2 reference, 3 midscale
   output reg filter_reset_out, // One-cycle filter reset pulse
   output reg data_ready_n_out,
   output reg irq_out,
   // AXI4-Lite slave
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // ==========================================
   // States, one-hot
   localparam [3:0] ST_RUN = 4'b0001; // Normal conversions
   localparam [3:0] ST_ZERO = 4'b0010; // Zero-scale conversion
   localparam [3:0] ST_FULL = 4'b0100; // Full-scale conversion
   localparam [3:0] ST_SETL = 4'b1000; // Filter resettling
   reg [3:0] state_r;
   reg [2:0] mode_r; // cal_mode_bits
   reg bipolar_r; // Bipolar range
   reg word24_r; // 24-bit result word
   reg [23:0] offs_r; // Offset coefficient
   reg [23:0] gain_r; // Full-scale coefficient
   reg [23:0] zero_meas_r; // Last zero-scale reading
   reg [3:0] per_r; // Output periods left in the calibration
   reg [2:0] bg_cnt_r; // Background slot counter
   reg [1:0] bg_valid_r; // Background results seen
   reg cmd_r; // Calibration command pulse
   reg [2:0] irq_stat_r; // 0 cal done, 1 data ready, 2 bad result
   reg [2:0] irq_en_r;
   wire tick; // Output period tick
   wire [23:0] corr; // Corrected result
   reg [23:0] res_r; // Result held from the last posted word
   wire busy; // Calibration in progress
   // Write handshake holding regs
   reg aw_hold_r;
   reg w_hold_r;
   reg [11:0] aw_addr_r;
   reg [31:0] w_data_r;
   wire do_wr;
   wire [23:0] span_code; // Measured span, gain derived from it
   assign busy = (state_r != ST_RUN);
   assign do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;
   // Reference span: full-scale reading minus zero; midscale in bipolar
   assign span_code = raw_data_in - zero_meas_r;
   // ==========================================
   // Submodules
   acs_timer u_timer (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .restart_in(cmd_r),
      .tick_out(tick)
   );
   acs_corr u_corr (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .raw_in(raw_data_in),
      .offs_in(offs_r),
      .gain_in(gain_r),
      .word24_in(word24_r),
      .res_out(corr)
   );
   // ==========================================
   // AXI write channel: take address and data in either order
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 12'h000;
         w_data_r <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
         end
         if (do_wr) begin
            // Unmapped offsets are answered with SLVERR
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_r[11:2] > 10'h007) ? 2'b10 : 2'b00;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   // ==========================================
   // AXI read channel: one cycle to answer
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
               `ACS_OFF_CTRL: s_axi_rdata <= {27'h0, word24_r, bipolar_r, mode_r};
               `ACS_OFF_STAT: s_axi_rdata <= {26'h0, bg_valid_r, state_r[3:1] != 3'h0,
                                             !data_ready_n_out, busy, 1'b0};
               `ACS_OFF_OFFS: s_axi_rdata <= {8'h00, offs_r};
               `ACS_OFF_GAIN: s_axi_rdata <= {8'h00, gain_r};
               `ACS_OFF_RES: s_axi_rdata <= {8'h00, res_r};
               `ACS_OFF_IRQS: s_axi_rdata <= {29'h0, irq_stat_r};
               `ACS_OFF_IRQC: s_axi_rdata <= 32'h0000_0000; // Write-only
               `ACS_OFF_IRQE: s_axi_rdata <= {29'h0, irq_en_r};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'b10; // Unmapped
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   // ==========================================
   // Control register and calibration sequencer
   // A control write with a calibration code starts a sequence
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         mode_r <= `ACS_MD_NORMAL;
         bipolar_r <= 1'b0;
         word24_r <= 1'b1;
         offs_r <= `ACS_OFFS_RST;
         gain_r <= `ACS_GAIN_RST;
         zero_meas_r <= 24'h00_0000;
         state_r <= ST_RUN;
         per_r <= 4'h0;
         cmd_r <= 1'b0;
         bg_cnt_r <= 3'h0;
         bg_valid_r <= 2'b00;
         filter_reset_out <= 1'b0;
         node_sel_out <= 2'b00;
      end else begin
         cmd_r <= 1'b0;
         filter_reset_out <= 1'b0;
         if (do_wr && aw_addr_r == `ACS_OFF_CTRL && s_axi_wstrb[0]) begin
            mode_r <= w_data_r[2:0];
            bipolar_r <= w_data_r[`ACS_CTRL_BIPOLAR];
            word24_r <= w_data_r[`ACS_CTRL_WORD24];
            if (w_data_r[2:0] != `ACS_MD_NORMAL && w_data_r[2:0] <= `ACS_MD_BGND) begin
               cmd_r <= 1'b1;
               filter_reset_out <= 1'b1;
               bg_cnt_r <= 3'h0;
               bg_valid_r <= 2'b00;
               case (w_data_r[2:0])
                  `ACS_MD_SELF: begin
                     state_r <= ST_ZERO;
                     per_r <= `ACS_PER_SELF;
                     node_sel_out <= w_data_r[3] ? 2'b11 : 2'b01;
                  end
                  `ACS_MD_SYS_ZERO: begin
                     state_r <= ST_ZERO;
                     per_r <= `ACS_PER_SYS;
                     node_sel_out <= 2'b00;
                  end
                  `ACS_MD_SYS_FULL: begin
                     state_r <= ST_FULL;
                     per_r <= `ACS_PER_SYS;
                     node_sel_out <= 2'b00;
                  end
                  `ACS_MD_SYS_OFFS: begin
                     state_r <= ST_ZERO;
                     per_r <= `ACS_PER_SELF;
                     node_sel_out <= 2'b00;
                  end
                  default: begin
                     // Background: run normally, calibrate in spare slots
                     state_r <= ST_RUN;
                     per_r <= 4'h0;
                     node_sel_out <= 2'b01;
                  end
               endcase
            end
         end else if (do_wr && aw_addr_r == `ACS_OFF_OFFS && !busy) begin
            offs_r <= w_data_r[23:0];
         end else if (do_wr && aw_addr_r == `ACS_OFF_GAIN && !busy) begin
            gain_r <= w_data_r[23:0];
         end else if (tick) begin
            case (state_r)
               ST_ZERO: begin
                  // Zero conversion takes the first period of the budget
                  per_r <= per_r - 4'h1;
                  zero_meas_r <= raw_data_in;
                  offs_r <= raw_data_in;
                  if (mode_r == `ACS_MD_SYS_ZERO) begin
                     state_r <= ST_SETL;
                  end else begin
                     state_r <= ST_FULL;
                     node_sel_out <= 2'b10;
                  end
               end
               ST_FULL: begin
                  per_r <= per_r - 4'h1;
                  // Gain scales measured span to full code, zero held at offset
                  gain_r <= (span_code == 24'h00_0000) ? gain_r :
                            24'h80_0000 + (24'h80_0000 - span_code[23:0]);
                  state_r <= ST_SETL;
                  node_sel_out <= 2'b00;
               end
               ST_SETL: begin
                  // Wait out the remaining budget for the filter to settle
                  if (per_r <= 4'h1) begin
                     state_r <= ST_RUN;
                     mode_r <= `ACS_MD_NORMAL;
                     per_r <= 4'h0;
                  end else begin
                     per_r <= per_r - 4'h1;
                  end
               end
               ST_RUN: begin
                  // Background slots: 0 shorted, 1 reference, rest input
                  if (mode_r == `ACS_MD_BGND) begin
                     bg_cnt_r <= (bg_cnt_r == `ACS_BGND_DIV - 3'h1) ? 3'h0 : bg_cnt_r + 3'h1;
                     if (bg_cnt_r == 3'h0)
                        offs_r <= raw_data_in;
                     if (bg_cnt_r == 3'h1)
                        gain_r <= 24'h80_0000 + (24'h80_0000 - span_code);
                     if (bg_cnt_r == 3'h0)
                        zero_meas_r <= raw_data_in;
                     node_sel_out <= (bg_cnt_r == 3'h0) ? 2'b10 :
                                     (bg_cnt_r == `ACS_BGND_DIV - 3'h1) ? 2'b01 : 2'b00;
                     if (bg_cnt_r == `ACS_BGND_DIV - 3'h1 && bg_valid_r != 2'b11)
                        bg_valid_r <= bg_valid_r + 2'b01;
                  end
               end
               default: state_r <= ST_RUN;
            endcase
         end
      end
   end
   // ==========================================
   // Data-ready output and interrupt logic
   wire new_word; // A usable result is posted this cycle
   wire cal_done; // Sequence finished this cycle
   assign cal_done = tick && state_r == ST_SETL && per_r <= 4'h1;
   assign new_word = tick && state_r == ST_RUN && (mode_r != `ACS_MD_BGND ||
                     bg_cnt_r == `ACS_BGND_DIV - 3'h1);
   // Busy raise happens on the command edge, well inside a modulator cycle
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         data_ready_n_out <= 1'b1;
         res_r <= 24'h00_0000;
         irq_stat_r <= 3'h0;
         irq_en_r <= 3'h0;
         irq_out <= 1'b0;
      end else begin
         // Only posted words reach the host, so calibration conversions stay hidden
         if (new_word)
            res_r <= corr;
         // The finishing tick still sees the settle state, so it must not hold busy
         if (cmd_r || (busy && !cal_done))
            data_ready_n_out <= 1'b1;
         else if (cal_done || new_word)
            data_ready_n_out <= 1'b0;
         else if (data_read_in)
            data_ready_n_out <= 1'b1;
         if (do_wr && aw_addr_r == `ACS_OFF_IRQE)
            irq_en_r <= w_data_r[2:0];
         // Set wins over a clear in the same cycle
         irq_stat_r <= (irq_stat_r & ~((do_wr && aw_addr_r == `ACS_OFF_IRQC) ?
                        w_data_r[2:0] : 3'h0)) |
                       {new_word && mode_r == `ACS_MD_BGND && bg_valid_r == 2'b00,
                        new_word, cal_done};
         irq_out <= |(irq_stat_r & irq_en_r);
      end
   end
endmodule // acs_seq

// ---- rtl/acs_timer.v ----
// Output-period timer: gives a one-cycle tick at each output period.
// Assumes the period constant fits in sixteen bits.
`timescale 1ns/100ps
`include "acs_regs.vh"
module acs_timer (
   input wire clock_in,
   input wire rst_in,
   input wire restart_in, // Realign to a fresh period
   output reg tick_out
);
   // ==========================================
   // Period counter
   reg [15:0] cnt_r; // Cycles left in the period
   // Count down; restart realigns so calibration timing begins at the command
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r <= 16'h0000;
         tick_out <= 1'b0;
      end else if (restart_in) begin
         cnt_r <= `ACS_OUT_PER - 16'h0001;
         tick_out <= 1'b0;
      end else if (cnt_r == 16'h0000) begin
         cnt_r <= `ACS_OUT_PER - 16'h0001;
         tick_out <= 1'b1;
      end else begin
         cnt_r <= cnt_r - 16'h0001;
         tick_out <= 1'b0;
      end
   end
endmodule // acs_timer

// ---- tb/acs_front_model.sv ----
// Converter front end: turns the selected node into a filter word.
// Assumes node_sel_out comes from the same clock domain.
`timescale 1ns/100ps
module acs_front_model (
   input wire clock_in,
   input wire [1:0] node_sel_in,
   input wire [23:0] analog_in, // System level, held per step by the bench
   output reg [23:0] raw_out
);
   // ==========================================
   // Node levels
   localparam [23:0] SHORT_CODE = 24'h00_0000; // Shorted inputs
   localparam [23:0] MID_CODE = 24'h80_0000; // Bipolar zero
   localparam [23:0] REF_CODE = 24'hF0_0000; // Reference, arbitrary level
   initial raw_out = 24'h00_0000;
   // Registered so the word lags the node switch like a real filter
   always @(posedge clock_in) begin
      case (node_sel_in)
         2'h1: raw_out <= SHORT_CODE;
         2'h2: raw_out <= REF_CODE;
         2'h3: raw_out <= MID_CODE;
         default: raw_out <= analog_in;
      endcase
   end
endmodule // acs_front_model

// ---- tb/acs_seq_properties.sv ----
// Checker for the calibration sequencer, bound to its top module.
// Assumes one clock domain with asynchronous active-high reset.
`timescale 1ns/100ps
module acs_seq_properties (
   input wire clock_in,
   input wire rst_in,
   input wire filter_reset_out,
   input wire data_ready_n_out,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata
);
   default clocking dc @(posedge clock_in); endclocking
   default disable iff (rst_in);
   // ==========================================
   // Clocks since the last command, saturating; starts full so that
   // normal results after reset never look like a short calibration
   reg [10:0] since_cmd_r;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         since_cmd_r <= 11'h7FF;
      end else if (filter_reset_out) begin
         since_cmd_r <= 11'h000;
      end else if (since_cmd_r != 11'h7FF) begin
         since_cmd_r <= since_cmd_r + 11'h001;
      end
   end
   // ==========================================
   // Properties
   chk_ready_busy: assert property (
      filter_reset_out |-> ##[0:16] data_ready_n_out) else $error("ready not raised");
   chk_cmd_hold: assert property (
      filter_reset_out |=> data_ready_n_out [*8]) else $error("ready low during cal");
   chk_filter_pulse: assert property (
      $rose(filter_reset_out) |=> !filter_reset_out) else $error("filter reset too long");
   chk_cal_span: assert property (
      $fell(data_ready_n_out) |-> since_cmd_r >= 11'h300) else $error("cal ended early");
   chk_write_resp: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("no write response");
   chk_bvalid_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   chk_read_resp: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read response");
   chk_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data moved");
endmodule // acs_seq_properties

bind acs_seq acs_seq_properties u_props (.clock_in(clock_in), .rst_in(rst_in),
   .filter_reset_out(filter_reset_out), .data_ready_n_out(data_ready_n_out),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ---- tb/tb.sv ----
// Self-checking bench for the calibration sequencer.
// Assumes the register map and timing of acs_regs.vh.
`timescale 1ns/100ps
`include "acs_regs.vh"
module tb;
   // ==========================================
   // Signals; ready channels held high, which the bus allows
   reg clock_in = 1'b0;
   reg rst_in = 1'b1;
   reg data_read_in = 1'b0;
   reg [23:0] analog_value = 24'h00_0000; // Level the system presents
   wire [23:0] raw_data_in;
   wire [1:0] node_sel_out;
   wire filter_reset_out, data_ready_n_out, irq_out;
   reg [11:0] awaddr = 12'h000, araddr = 12'h000;
   reg [31:0] wdata = 32'h0000_0000;
   reg awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   wire awready, wready, bvalid, arready, rvalid;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int n_errors = 0, n_tests = 0, cyc = 0, i, n;
   reg [31:0] rd, g0;
   reg [1:0] rr, first;
   reg [3:0] seen;
   reg [23:0] raw, offs;
   reg [23:0] gain_tab [0:1] = '{24'h80_0000, 24'h40_0000};
   reg [7:0] cal_ctrl [0:5] = '{8'h11, 8'h19, 8'h12, 8'h13, 8'h12, 8'h14};
   reg [3:0] cal_mask [0:5] = '{4'h6, 4'hC, 4'h0, 4'h0, 4'h0, 4'h4};
   reg [1:0] cal_first [0:5] = '{2'h1, 2'h3, 2'h0, 2'h0, 2'h0, 2'h2};
   int cal_per [0:5] = '{9, 9, 4, 4, 4, 9};
   always #25 clock_in = ~clock_in;
   acs_seq dut (.clock_in(clock_in), .rst_in(rst_in), .raw_data_in(raw_data_in),
      .data_read_in(data_read_in), .node_sel_out(node_sel_out),
      .filter_reset_out(filter_reset_out), .data_ready_n_out(data_ready_n_out),
      .irq_out(irq_out), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
   acs_front_model model (.clock_in(clock_in), .node_sel_in(node_sel_out),
      .analog_in(analog_value), .raw_out(raw_data_in));
   // ==========================================
   // Helpers
   task complete_run;
      begin
         $display("Checks %0d, mismatches %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      begin
         n_tests++;
         if (g !== e) begin
            n_errors++;
            $display("ERROR at %0t: got %h, expected %h", $time, g, e);
         end
      end
   endtask
   // Counts are bench values, so a plain window test is enough
   task near(input int v, input int e, input int tol);
      chk(v >= e - tol && v <= e + tol, 1'b1);
   endtask
   // Offset first, then gain as unsigned 1.23
   function automatic [23:0] exp_res(input [23:0] r, input [23:0] o, input [23:0] g);
      reg [47:0] p;
      begin
         p = {24'h00_0000, r - o} * {24'h00_0000, g};
         exp_res = p[46:23];
      end
   endfunction
   task axi_wr(input [11:0] a, input [31:0] v);
      begin
         awaddr <= a;
         wdata <= v;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         do begin
            @(posedge clock_in);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
         end while (!bvalid);
         rr = bresp;
      end
   endtask
   task axi_rd(input [11:0] a);
      begin
         araddr <= a;
         arvalid <= 1'b1;
         do begin
            @(posedge clock_in);
            if (arready) arvalid <= 1'b0;
         end while (!rvalid);
         rd = rdata;
         rr = rresp;
      end
   endtask
   task ack;
      begin
         data_read_in <= 1'b1;
         @(posedge clock_in);
         data_read_in <= 1'b0;
      end
   endtask
   // Waits for a result, noting which nodes were visited meanwhile
   task wait_rdy(input int skip, output int c);
      begin
         c = 0;
         seen = 4'h0;
         first = 2'h0;
         do begin
            @(posedge clock_in);
            c++;
            seen[node_sel_out] = 1'b1;
            if (first == 2'h0) first = node_sel_out;
         end while (c <= skip || data_ready_n_out);
      end
   endtask
   // Hang guard, well above the roughly 15000 cycles needed
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         complete_run;
      end
   end
   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(42091));
      repeat (5) @(posedge clock_in);
      rst_in <= 1'b0;
      @(posedge clock_in);
      axi_rd(`ACS_OFF_GAIN);
      chk(rd, 32'h0080_0000);
      axi_rd(`ACS_OFF_CTRL);
      chk(rd, 32'h0000_0010);
      axi_rd(12'h020);
      chk(rr, 2'h2);
      axi_wr(12'h020, 32'h0000_0000);
      chk(rr, 2'h2);
      for (i = 0; i < 2; i++) begin
         raw = 24'h40_0000 + 24'($urandom_range(0, 32'h003F_FFFF));
         offs = 24'($urandom_range(0, 32'h000F_FFFF));
         analog_value <= raw;
         axi_wr(`ACS_OFF_OFFS, {8'h00, offs});
         axi_wr(`ACS_OFF_GAIN, {8'h00, gain_tab[i]});
         axi_rd(`ACS_OFF_OFFS);
         chk(rd, {8'h00, offs});
         wait_rdy(2, n);
         ack;
         wait_rdy(2, n);
         axi_rd(`ACS_OFF_RES);
         chk(rd, {8'h00, exp_res(raw, offs, gain_tab[i])});
         ack;
      end
      axi_wr(`ACS_OFF_IRQC, 32'h0000_0007);
      axi_wr(`ACS_OFF_IRQE, 32'h0000_0001);
      // Codes 001 to 100 in turn; only the first may interrupt
      for (i = 0; i < 6; i++) begin
         analog_value <= 24'h40_0000 + 24'($urandom_range(0, 32'h000F_FFFF));
         axi_rd(`ACS_OFF_GAIN);
         g0 = rd;
         axi_wr(`ACS_OFF_CTRL, {24'h00_0000, cal_ctrl[i]});
         wait_rdy(16, n);
         chk(seen & 4'hE, cal_mask[i]);
         chk(first, cal_first[i]);
         near(n, cal_per[i] * `ACS_OUT_PER, 40);
         repeat (2) @(posedge clock_in);
         chk(irq_out, i == 0);
         axi_rd(`ACS_OFF_GAIN);
         if (i == 4) chk(rd, g0);
         ack;
         axi_wr(`ACS_OFF_IRQC, 32'h0000_0007);
         axi_wr(`ACS_OFF_IRQE, 32'h0000_0000);
         repeat (2) @(posedge clock_in);
         chk(irq_out, 1'b0);
      end
      // Background mode, then back to normal rate
      axi_wr(`ACS_OFF_CTRL, 32'h0000_0015);
      wait_rdy(16, n);
      near(n, 6 * `ACS_OUT_PER, 40);
      ack;
      wait_rdy(2, n);
      near(n, 6 * `ACS_OUT_PER, 40);
      axi_rd(`ACS_OFF_IRQS);
      chk(rd[2], 1'b1);
      axi_rd(`ACS_OFF_CTRL);
      chk(rd[2:0], 3'h5);
      ack;
      axi_wr(`ACS_OFF_CTRL, 32'h0000_0010);
      wait_rdy(16, n);
      ack;
      wait_rdy(2, n);
      near(n, `ACS_OUT_PER, 40);
      complete_run;
   end
endmodule // tb
